/* File: hw/smc_pkg.sv */
// constants shared by the sleep mode controller
package smc_pkg;
  // ---------------------------------------------------------------
  // register byte addresses on the apb slave
  // ---------------------------------------------------------------
  localparam logic [7:0] SMC_STATUS_OFS = 8'h00;
  localparam logic [7:0] SMC_CTRL_OFS = 8'h04;
  localparam logic [7:0] SMC_IRQEN_OFS = 8'h08;
  localparam logic [7:0] SMC_IRQFLAG_OFS = 8'h0C;
  localparam logic [7:0] SMC_STATE_OFS = 8'h10;
  localparam logic [7:0] SMC_CONFIG_OFS = 8'h14;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SMC_TO_BIT = 4; // timeout_flag in status
  localparam int SMC_PD_BIT = 3; // power_down_flag in status
  localparam int SMC_GIE_BIT = 0; // global_irq_enable in ctrl
  localparam int SMC_WSR_BIT = 1; // watchdog runs in sleep
  localparam int SMC_ADCRC_BIT = 2; // adc on dedicated rc clock
  localparam int SMC_MCLREN_BIT = 0; // config: pin reset enable
  localparam int SMC_BOREN_BIT = 1; // config: brownout enable
  localparam int SMC_VCSEL_BIT = 2; // config: regulator_pin_select
  localparam int SMC_OSC_LSB = 3; // config: oscillator mode, 2 bits
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SMC_STATUS_RST = 8'h18;
  localparam logic [7:0] SMC_CTRL_RST = 8'h00;
  localparam logic [7:0] SMC_CONFIG_RST = 8'h03;
  // ---------------------------------------------------------------
  // oscillator modes and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] SMC_OSC_INT = 2'h0; // no start-up delay
  localparam logic [1:0] SMC_OSC_XT = 2'h1; // crystal_standard_mode
  localparam logic [1:0] SMC_OSC_HS = 2'h2; // crystal_high_speed_mode
  localparam logic [1:0] SMC_OSC_LP = 2'h3; // crystal_low_power_mode
  localparam int SMC_OST_PERIODS = 1024; // osc_startup_delay
  localparam int SMC_OST_CYCLES = SMC_OST_PERIODS; // osc is pclk
  localparam int SMC_FNOP_CYCLES = 2; // forced no-ops before isr
  localparam logic [13:0] SMC_ISR_VEC = 14'h0004;
  // ---------------------------------------------------------------
  // controller states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SMC_AWAKE, SMC_ASLEEP, SMC_OST, SMC_EXEC, SMC_FNOP
  } smc_state_t;
endpackage : smc_pkg

/* File: hw/smc_sleep_ctrl.sv */
// sleep mode controller: sleep entry, wake, status flags, apb regs
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - sleep entered only by sleep instruction
// - entry clears watchdog, runs if sleep-enabled
// - entry clears power_down_flag, sets timeout_flag
// - cpu clock stopped while asleep
// - low freq, timer1, sensing oscillators keep running
// - adc runs in sleep on rc clock
// - pins hold pre-sleep drive state
// - non-watchdog resets act same in sleep
// - wake on resets, watchdog, enabled interrupts
// - reset events reset; others continue execution
// - sleep prefetches the next instruction
// - irq wake needs own enable, not gie
// - run prefetched, then inline or isr 0004h
// - every interrupt or watchdog wake clears the watchdog
// - pending irq makes sleep a no-operation
// - irq during sleep: complete, wake at once
// - crystal wake waits 1024 oscillator periods
// - hold reset until regulator cap charged
// - regulator_pin_select picks cap pin
// - flags set regardless of enables
module smc_sleep_ctrl
  import smc_pkg::*;
#(
  parameter int N_IRQ = 8, // interrupt sources
  parameter int IO_W = 8 // held i/o pins
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_sleep_exec,
  input wire logic external_reset_pin_n,
  input wire logic brownout_n,
  input wire logic power_on_n,
  input wire logic cap_charged,
  input wire logic regulator_present,
  input wire logic wdt_timeout,
  input wire logic [N_IRQ-1:0] irq_src,
  input wire logic [IO_W-1:0] io_out_in,
  input wire logic [IO_W-1:0] io_oe_in,
  output logic [IO_W-1:0] io_out,
  output logic [IO_W-1:0] io_oe,
  output logic cpu_clk_en,
  output logic core_reset,
  output logic wdt_clear,
  output logic wdt_run,
  output logic fetch_next,
  output logic exec_prefetch,
  output logic resume_inline,
  output logic forced_nop,
  output logic isr_call,
  output logic [13:0] isr_vector,
  output logic lfosc_en,
  output logic t1osc_en,
  output logic sense_osc_en,
  output logic adc_clk_en,
  output logic cap_on_port_f_bit0
);
  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (N_IRQ < 1 || N_IRQ > 8) begin : g_chk_irq
    $error("N_IRQ must be 1 to 8");
  end
  if (IO_W < 1) begin : g_chk_io
    $error("IO_W must be at least 1");
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int SW = N_IRQ + 5; // sync vector width
  logic [SW-1:0] s1_reg; // first stage, read only by s2
  logic [SW-1:0] s2_reg;
  logic [SW-1:0] s3_reg;
  logic [SW-1:0] filt_reg; // agreed value
  logic [SW-1:0] filt_d_reg; // previous agreed value
  wire [SW-1:0] raw_in = {irq_src, wdt_timeout, cap_charged,
    ~power_on_n, ~brownout_n, ~external_reset_pin_n};

  // three stages; value changes once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
      filt_d_reg <= '0;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s2_reg == s3_reg) ? s3_reg : filt_reg;
      filt_d_reg <= filt_reg;
    end
  end

  wire external_reset_pin_lvl = filt_reg[0];
  wire bor_lvl = filt_reg[1];
  wire por_lvl = filt_reg[2];
  wire cap_ok = filt_reg[3];
  wire wdt_evt = filt_reg[4] & ~filt_d_reg[4]; // time-out edge
  wire [N_IRQ-1:0] irq_edge =
    filt_reg[SW-1:5] & ~filt_d_reg[SW-1:5];

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  logic [7:0] status_reg, status_next; // core_status_flags
  logic [7:0] ctrl_reg; // gie, watchdog-in-sleep, adc rc clock
  logic [7:0] irqen_reg; // individual enables
  logic [7:0] irqflag_reg, irqflag_next; // pending flags
  logic [7:0] config_reg; // configuration bits
  smc_state_t state_reg, state_next;
  logic [10:0] cnt_reg, cnt_next; // start-up and no-op counter

  wire global_irq_enable = ctrl_reg[SMC_GIE_BIT];
  wire wdt_in_sleep = ctrl_reg[SMC_WSR_BIT];
  wire [1:0] osc_mode = config_reg[SMC_OSC_LSB +: 2];
  wire crystal = (osc_mode != SMC_OSC_INT);

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire hit_st = (paddr == SMC_STATUS_OFS);
  wire hit_ct = (paddr == SMC_CTRL_OFS);
  wire hit_en = (paddr == SMC_IRQEN_OFS);
  wire hit_fl = (paddr == SMC_IRQFLAG_OFS);
  wire hit_sm = (paddr == SMC_STATE_OFS);
  wire hit_cf = (paddr == SMC_CONFIG_OFS);
  wire mapped = hit_st | hit_ct | hit_en | hit_fl | hit_sm | hit_cf;
  wire [7:0] rd_byte =
    hit_st ? status_reg :
    hit_ct ? ctrl_reg :
    hit_en ? irqen_reg :
    hit_fl ? irqflag_reg :
    hit_sm ? {5'h00, state_reg} :
    hit_cf ? config_reg : 8'h00;

  // answer in the first access cycle; data captured in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup & ~pwrite) ? {24'h000000, rd_byte} : prdata;
    end
  end

  // plain control registers, writes only at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= SMC_CTRL_RST;
      irqen_reg <= 8'h00;
      config_reg <= SMC_CONFIG_RST;
    end else begin
      if (wr && hit_ct) begin
        ctrl_reg <= {5'h00, pwdata[2:0]};
      end
      if (wr && hit_en) begin
        irqen_reg <= pwdata[7:0];
      end
      if (wr && hit_cf) begin
        config_reg <= {3'h0, pwdata[4:0]};
      end
    end
  end

  // ---------------------------------------------------------------
  // wake and reset conditions
  // ---------------------------------------------------------------
  wire [7:0] edge8 = 8'(irq_edge);
  wire irq_pend = |(irqflag_reg & irqen_reg);
  wire por_hold = por_lvl | (regulator_present & ~cap_ok);
  // pin and brownout resets act in every state alike
  wire rst_evt = por_hold | (external_reset_pin_lvl & config_reg[SMC_MCLREN_BIT]) |
    (bor_lvl & config_reg[SMC_BOREN_BIT]);
  wire sleep_go = cpu_sleep_exec & (state_reg == SMC_AWAKE);
  wire wdt_wake = wdt_evt & wdt_in_sleep;
  wire asleep = (state_reg == SMC_ASLEEP);
  wire wake = asleep & (irq_pend | wdt_wake);

  // flags: hardware set wins over a write-one-to-clear
  always_comb begin
    irqflag_next = irqflag_reg;
    if (wr && hit_fl) begin
      irqflag_next = irqflag_reg & ~pwdata[7:0];
    end
    irqflag_next = irqflag_next | edge8;
  end

  // ---------------------------------------------------------------
  // sleep state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    status_next = status_reg;
    if (wr && hit_st) begin
      status_next[2:0] = pwdata[2:0]; // arithmetic flags only
    end
    case (state_reg)
      SMC_AWAKE: begin
        // pending enabled flag turns sleep into no-op
        if (sleep_go && !irq_pend) begin
          state_next = SMC_ASLEEP;
          status_next[SMC_PD_BIT] = 1'b0;
          status_next[SMC_TO_BIT] = 1'b1;
        end else if (wdt_evt) begin
          status_next[SMC_TO_BIT] = 1'b0; // awake time-out resets
        end
      end
      SMC_ASLEEP: begin
        // a flag raised during entry wakes the very next cycle
        if (wake) begin
          cnt_next = 11'h000;
          state_next = crystal ? SMC_OST : SMC_EXEC;
          if (!irq_pend) begin
            status_next[SMC_TO_BIT] = 1'b0; // watchdog wake
          end
        end
      end
      SMC_OST: begin
        cnt_next = cnt_reg + 11'h001;
        if (cnt_reg == 11'(SMC_OST_CYCLES - 1)) begin
          state_next = SMC_EXEC;
        end
      end
      SMC_EXEC: begin
        cnt_next = 11'h000;
        state_next = global_irq_enable ? SMC_FNOP : SMC_AWAKE;
      end
      SMC_FNOP: begin
        cnt_next = cnt_reg + 11'h001;
        if (cnt_reg == 11'(SMC_FNOP_CYCLES - 1)) begin
          state_next = SMC_AWAKE;
        end
      end
      default: begin
        state_next = SMC_AWAKE;
      end
    endcase
    if (rst_evt) begin
      state_next = SMC_AWAKE;
      status_next[SMC_TO_BIT] = 1'b1;
      status_next[SMC_PD_BIT] = 1'b1;
    end
  end

  // state, counter, flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SMC_AWAKE;
      cnt_reg <= 11'h000;
      status_reg <= SMC_STATUS_RST;
      irqflag_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      status_reg <= status_next;
      irqflag_reg <= irqflag_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all registered
  // ---------------------------------------------------------------
  wire in_ost_next = (state_next == SMC_OST);
  wire sleep_next = (state_next == SMC_ASLEEP);
  wire fnop_end = (state_reg == SMC_FNOP) & (state_next == SMC_AWAKE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en <= 1'b1;
      core_reset <= 1'b1;
      wdt_clear <= 1'b1;
      wdt_run <= 1'b1;
      fetch_next <= 1'b0;
      exec_prefetch <= 1'b0;
      resume_inline <= 1'b0;
      forced_nop <= 1'b0;
      isr_call <= 1'b0;
    end else begin
      cpu_clk_en <= ~sleep_next & ~in_ost_next;
      core_reset <= rst_evt | (wdt_evt & ~asleep);
      // cleared at entry, on wake and through start-up
      wdt_clear <= (sleep_go & ~irq_pend) | wake | in_ost_next;
      wdt_run <= ~sleep_next | wdt_in_sleep;
      fetch_next <= sleep_go;
      exec_prefetch <= (state_next == SMC_EXEC);
      resume_inline <= (state_reg == SMC_EXEC) & ~global_irq_enable & ~rst_evt;
      forced_nop <= (state_next == SMC_FNOP);
      isr_call <= fnop_end;
    end
  end

  // pins freeze in their pre-sleep drive state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_out <= '0;
      io_oe <= '0;
    end else if (!sleep_next || !asleep) begin
      io_out <= io_out_in;
      io_oe <= io_oe_in;
    end
  end

  // clock and pin enables for the parts that outlive sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfosc_en <= 1'b1;
      t1osc_en <= 1'b1;
      sense_osc_en <= 1'b1;
      adc_clk_en <= 1'b1;
      cap_on_port_f_bit0 <= 1'b0;
      isr_vector <= SMC_ISR_VEC;
    end else begin
      lfosc_en <= 1'b1;
      t1osc_en <= 1'b1;
      sense_osc_en <= 1'b1;
      adc_clk_en <= ~sleep_next | ctrl_reg[SMC_ADCRC_BIT];
      cap_on_port_f_bit0 <= ~config_reg[SMC_VCSEL_BIT];
      isr_vector <= SMC_ISR_VEC;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_entry;
    sleep_go && !irq_pend && !rst_evt;
  endsequence

  property p_enter;
    @(posedge pclk) disable iff (!presetn)
      s_entry |=> asleep && !cpu_clk_en;
  endproperty
  a_enter: assert property (p_enter)
    else $error("sleep entry did not stop cpu clock");

  property p_flags;
    @(posedge pclk) disable iff (!presetn)
      s_entry |=> !status_reg[SMC_PD_BIT] && status_reg[SMC_TO_BIT];
  endproperty
  a_flags: assert property (p_flags)
    else $error("entry flags wrong");

  property p_wdclr;
    @(posedge pclk) disable iff (!presetn)
      s_entry |=> wdt_clear && (wdt_run == wdt_in_sleep);
  endproperty
  a_wdclr: assert property (p_wdclr)
    else $error("watchdog not cleared at entry");

  property p_nop;
    @(posedge pclk) disable iff (!presetn)
      sleep_go && irq_pend && !rst_evt |=>
        $stable(status_reg[4:3]) && !asleep && !wdt_clear;
  endproperty
  a_nop: assert property (p_nop)
    else $error("pending irq sleep was not a no-op");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      asleep && $past(asleep) |-> $stable(io_out) && $stable(io_oe);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pins moved while asleep");

  property p_ost;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == SMC_OST) |-> wdt_clear && !cpu_clk_en;
  endproperty
  a_ost: assert property (p_ost)
    else $error("start-up delay let cpu run");

  sequence s_gie_wake;
    wake && irq_pend && global_irq_enable && !crystal && !rst_evt;
  endsequence

  // wake cycle, one prefetch cycle, then two no-ops and the vector call
  property p_isr;
    @(posedge pclk) disable iff (!presetn)
      s_gie_wake ##1 (!rst_evt) [*3] |->
        $past(forced_nop) && forced_nop ##1 isr_call;
  endproperty
  a_isr: assert property (p_isr)
    else $error("isr call not after forced no-ops");

  property p_reset;
    @(posedge pclk) disable iff (!presetn)
      rst_evt |=> core_reset && status_reg[SMC_PD_BIT];
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset event did not reset core");

  property p_flagset;
    @(posedge pclk) disable iff (!presetn)
      irq_edge[0] |=> irqflag_reg[0];
  endproperty
  a_flagset: assert property (p_flagset)
    else $error("irq edge lost");

  property p_adc;
    @(posedge pclk) disable iff (!presetn)
      asleep && $past(asleep) && ctrl_reg[SMC_ADCRC_BIT] &&
        $past(ctrl_reg[SMC_ADCRC_BIT]) |-> adc_clk_en;
  endproperty
  a_adc: assert property (p_adc)
    else $error("adc clock stopped in sleep");
endmodule : smc_sleep_ctrl

`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the sleep mode controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import smc_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic cpu_sleep_exec = 1'b0; // one-cycle sleep instruction strobe
  logic external_reset_pin_n = 1'b1, brownout_n = 1'b1, power_on_n = 1'b1;
  logic cap_charged = 1'b0; // starts low to see the regulator hold
  logic regulator_present = 1'b1, wdt_timeout = 1'b0;
  logic [7:0] irq_src = 8'h00, io_out_in = 8'h00, io_oe_in = 8'h00;
  logic [7:0] io_out, io_oe;
  logic cpu_clk_en, core_reset, wdt_clear, wdt_run, fetch_next;
  logic exec_prefetch, resume_inline, forced_nop, isr_call;
  logic [13:0] isr_vector;
  logic lfosc_en, t1osc_en, sense_osc_en, adc_clk_en, cap_on_port_f_bit0;
  int miscompares = 0, check_count = 0;
  int stat_m = 32'h18; // model of the status flags
  int k, n, ex_i, nf, nl, is_i, ri;
  logic [31:0] rd;
  logic er;
  logic [7:0] v, vo;
  smc_sleep_ctrl #(.N_IRQ(8), .IO_W(8)) u_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_sleep_exec(cpu_sleep_exec),
    .external_reset_pin_n(external_reset_pin_n), .brownout_n(brownout_n),
    .power_on_n(power_on_n), .cap_charged(cap_charged),
    .regulator_present(regulator_present), .wdt_timeout(wdt_timeout),
    .irq_src(irq_src), .io_out_in(io_out_in), .io_oe_in(io_oe_in),
    .io_out(io_out), .io_oe(io_oe), .cpu_clk_en(cpu_clk_en),
    .core_reset(core_reset), .wdt_clear(wdt_clear), .wdt_run(wdt_run),
    .fetch_next(fetch_next), .exec_prefetch(exec_prefetch),
    .resume_inline(resume_inline), .forced_nop(forced_nop),
    .isr_call(isr_call), .isr_vector(isr_vector), .lfosc_en(lfosc_en),
    .t1osc_en(t1osc_en), .sense_osc_en(sense_osc_en),
    .adc_clk_en(adc_clk_en), .cap_on_port_f_bit0(cap_on_port_f_bit0));
  // ----------------------------------------------------------------
  // clock, verdict and shared tasks
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  task automatic final_report;
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  // a spent wait is a failure; stop rather than cascade
  task automatic tmo;
    miscompares++;
    final_report();
  endtask : tmo
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int c;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (pready !== 1'b1 && c < 20);
    if (c >= 20) tmo();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk
  // strobe the sleep instruction, settle past the accepting edge
  task automatic sleep_op;
    @(posedge pclk);
    cpu_sleep_exec <= 1'b1; // prefetched word is a no-op
    @(posedge pclk);
    cpu_sleep_exec <= 1'b0;
    #1;
  endtask : sleep_op
  // count cycles until the cpu clock returns, bounded
  task automatic wait_wake(input int lim);
    n = 0;
    while (cpu_clk_en !== 1'b1) begin
      @(posedge pclk);
      #1;
      n++;
      if (n > lim) tmo();
    end
  endtask : wait_wake
  // log the resume sequence: prefetch, forced no-ops, vector call
  task automatic trace;
    ex_i = -1; nf = 0; nl = -1; is_i = -1; ri = -1;
    for (int i = 0; i < 12; i++) begin
      if (exec_prefetch === 1'b1 && ex_i < 0) ex_i = i;
      if (forced_nop === 1'b1) begin
        nf++;
        nl = i;
      end
      if (isr_call === 1'b1 && is_i < 0) is_i = i;
      if (resume_inline === 1'b1 && ri < 0) ri = i;
      @(posedge pclk);
      #1;
    end
  endtask : trace
  // drop the sources and clear every flag
  task automatic clr_irq;
    @(posedge pclk);
    irq_src <= 8'h00;
    wdt_timeout <= 1'b0;
    apb(1'b1, SMC_IRQFLAG_OFS, 32'hFF);
  endtask : clr_irq
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hAC51));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    #1;
    chk("core_reset hold", 32'h1, core_reset);
    cap_charged <= 1'b1;
    n = 0;
    while (core_reset !== 1'b0) begin
      @(posedge pclk);
      n++;
      if (n > 20) tmo();
    end
    rdchk("status rst", SMC_STATUS_OFS, 32'h18);
    rdchk("config rst", SMC_CONFIG_OFS, 32'h03);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    // both selections of the regulator capacitor pin
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, SMC_CONFIG_OFS, 32'h03 | (s << 2));
      repeat (2) @(posedge pclk);
      chk("cap pin", 32'(1 - s), cap_on_port_f_bit0);
    end
    // a disabled source sets its flag but must not block sleep
    k = $urandom % 8;
    apb(1'b1, SMC_IRQEN_OFS, 32'h1 << k);
    io_out_in <= $urandom;
    io_oe_in <= $urandom;
    @(posedge pclk);
    irq_src <= 8'h1 << ((k + 1) % 8);
    repeat (8) @(posedge pclk);
    rdchk("flag unmasked", SMC_IRQFLAG_OFS, 32'h1 << ((k + 1) % 8));
    v = io_out_in;
    vo = io_oe_in;
    sleep_op();
    chk("fetch_next", 32'h1, fetch_next);
    chk("clk stop", 32'h0, cpu_clk_en);
    chk("wdt clear in", 32'h1, wdt_clear);
    stat_m = 32'h10;
    io_out_in <= ~v;
    io_oe_in <= ~vo;
    repeat (20) @(posedge pclk);
    #1;
    chk("still asleep", 32'h0, cpu_clk_en);
    chk("pins held", v, io_out);
    chk("oe held", vo, io_oe);
    chk("wdt run off", 32'h0, wdt_run);
    chk("osc on", 32'h7, {lfosc_en, t1osc_en, sense_osc_en});
    chk("adc off", 32'h0, adc_clk_en);
    rdchk("status slp", SMC_STATUS_OFS, stat_m);
    // enabled source wakes with interrupts globally off
    irq_src[k] <= 1'b1;
    wait_wake(20);
    chk("wdt clr wake", 32'h1, wdt_clear);
    trace();
    chk("exec prefetch", 32'h1, 32'(ex_i >= 0));
    chk("inline", 32'h1, 32'(ri > ex_i && is_i < 0 && nf == 0));
    rdchk("status wake", SMC_STATUS_OFS, stat_m);
    // same wake with interrupts on: two no-ops then the vector
    apb(1'b1, SMC_CTRL_OFS, 32'h05);
    clr_irq();
    sleep_op();
    #1;
    chk("adc on", 32'h1, adc_clk_en);
    irq_src[k] <= 1'b1;
    wait_wake(20);
    trace();
    chk("fnop count", SMC_FNOP_CYCLES, nf);
    chk("isr order", 32'h1, 32'(ex_i >= 0 && ex_i < nl && is_i == nl + 1));
    chk("isr vec", SMC_ISR_VEC, isr_vector);
    // pending enabled flag turns sleep into a no-operation
    // flags keep the values left by the last real sleep
    apb(1'b1, SMC_STATUS_OFS, 32'h0);
    apb(1'b1, SMC_CTRL_OFS, 32'h00);
    sleep_op();
    chk("nop fetch", 32'h1, fetch_next);
    chk("nop clk", 32'h1, cpu_clk_en);
    chk("nop wdt", 32'h0, wdt_clear);
    repeat (4) @(posedge pclk);
    rdchk("nop status", SMC_STATUS_OFS, stat_m & 32'h18);
    // crystal mode holds the clock for the start-up delay
    clr_irq();
    apb(1'b1, SMC_CONFIG_OFS, 32'h03 | (SMC_OSC_XT << SMC_OSC_LSB));
    sleep_op();
    @(posedge pclk);
    irq_src[k] <= 1'b1;
    wait_wake(SMC_OST_CYCLES + 20);
    chk("ost lo", 32'h1, 32'(n >= SMC_OST_CYCLES));
    chk("ost hi", 32'h1, 32'(n <= SMC_OST_CYCLES + 12));
    // watchdog wake with the watchdog allowed to run in sleep
    clr_irq();
    apb(1'b1, SMC_CONFIG_OFS, 32'h03);
    apb(1'b1, SMC_CTRL_OFS, 32'h02);
    sleep_op();
    #1;
    chk("wdt run on", 32'h1, wdt_run);
    wdt_timeout <= 1'b1;
    wait_wake(20);
    stat_m = 32'h00;
    rdchk("status wdt", SMC_STATUS_OFS, stat_m);
    chk("no reset", 32'h0, core_reset);
    // pin reset while asleep still resets the core
    clr_irq();
    sleep_op();
    external_reset_pin_n <= 1'b0;
    repeat (8) @(posedge pclk);
    #1;
    chk("pin reset", 32'h1, core_reset);
    external_reset_pin_n <= 1'b1;
    n = 0;
    while (core_reset !== 1'b0) begin
      @(posedge pclk);
      n++;
      if (n > 20) tmo();
    end
    apb(1'b0, SMC_STATUS_OFS, 32'h0);
    chk("status rst ev", 32'h18, rd & 32'h18);
    final_report();
  end
  // hang guard at 40000 cycles, far above the test's run length
  initial begin
    #200000;
    tmo();
  end
endmodule : tb
`default_nettype wire
